// File: tpg_consts.vh
// Purpose: Constants for the buzzer tone generator
// Assumes: Wishbone classic slave, 8-bit data in low bits of a 32-bit word
// Notes:   Offsets are byte addresses
`ifndef TPG_CONSTS_VH
`define TPG_CONSTS_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define TPG_ADDR_W          12
`define TPG_OFF_FUNC        12'h0f4
`define TPG_OFF_PERIOD      12'h0f8
`define TPG_OFF_PORT_OUT    12'h0fc
`define TPG_OFF_PORT_DIR    12'h100
`define TPG_OFF_STATUS      12'h104

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define TPG_FUNC_TONE_BIT   3
`define TPG_LINE3_BIT       3
`define TPG_PER_LSB         0
`define TPG_PER_MSB         5
`define TPG_PSC_LSB         6
`define TPG_PSC_MSB         7
`define TPG_RST_BYTE        8'h00
`define TPG_RST_PERIOD      6'h00
`define TPG_RST_PSC         2'h0
`define TPG_PER_ZERO        6'h00
`define TPG_PSC_BASE_DIV    4

`endif

// File: tpg_prescaler.v
// Purpose: Prescaler giving a one-cycle tick every 4, 8, 16 or 32 clocks
// Assumes: Same clock and reset as the parent
// Notes:   Restart returns the divider to zero
`timescale 1ns/100ps
`default_nettype none
`include "tpg_consts.vh"

module tpg_prescaler #(
  parameter CNT_W = 5
) (
  input  wire       ref_clk,  // System clock
  input  wire       rst_n,    // Async reset, active low
  input  wire       restart,  // Clear divider
  input  wire [1:0] sel,      // Ratio code
  output reg        tick      // One-cycle prescaled clock
);

  reg  [CNT_W-1:0] div_r;
  wire [CNT_W-1:0] last;
  wire [31:0]      last_full;

  // Ratio = 4 << sel, terminal count ratio - 1; cut to the divider width
  assign last_full = (`TPG_PSC_BASE_DIV << sel) - 1;
  assign last      = last_full[CNT_W-1:0];

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= {CNT_W{1'b0}};
      tick  <= 1'b0;
    end else if (restart) begin
      div_r <= {CNT_W{1'b0}};
      tick  <= 1'b0;
    end else if (div_r == last) begin
      div_r <= {CNT_W{1'b0}};
      tick  <= 1'b1;
    end else begin
      div_r <= div_r + 1'b1;
      tick  <= 1'b0;
    end
  end

endmodule // tpg_prescaler
`default_nettype wire

// File: tpg_tone_gen.v
// Purpose: Square-wave tone generator for a piezo buzzer on port 0 line 3
// Assumes: Wishbone classic slave, ref_clk 10 MHz, single clock domain
// Notes:   Period register is write-only; reads of it return zero
//
// Summary of operation
// R1 - The tone comes from a 6-bit counter, a period register and a prescaled clock selector.
// R2 - The tone output is a square wave with equal high and low times.
// R3 - The tone reaches port0_line3 only while bit 3 of port0_function_select at 0x0f4 is 1.
// R4 - Software also sets bit 3 of port0_direction so the line is an output.
// R5 - The tone period comes from bits 0 to 5 of tone_period_prescale.
// R6 - Tone frequency is oscillator / (2 x prescale ratio x (period + 1)).
// R7 - Bits 7:6 select a prescale ratio of 4, 8, 16 or 32.
// R8 - Software loads a period of 1 to 0x3f before enabling the tone.
// R9 - The period register is write-only and never reads back.
// R10 - Any period register write with byte lane 0 selected clears the counter and restarts with the new settings.
// R11 - The counter counts prescaled clocks from zero until it equals the period field.
// R12 - On each match the output toggles and the counter returns to zero.
// R13 - A zero period holds the tone output static.
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "tpg_consts.vh"

module tpg_tone_gen #(
  parameter PER_W = 6
) (
  input  wire        ref_clk,      // 10 MHz clock
  input  wire        rst_n,        // Async reset, active low
  input  wire        wb_cyc_i,     // Wishbone cycle
  input  wire        wb_stb_i,     // Wishbone strobe
  input  wire        wb_we_i,      // Wishbone write enable
  input  wire [11:0] wb_adr_i,     // Wishbone byte address
  input  wire [31:0] wb_dat_i,     // Wishbone write data
  input  wire [3:0]  wb_sel_i,     // Wishbone byte selects
  output reg  [31:0] wb_dat_o,     // Wishbone read data
  output reg         wb_ack_o,     // Wishbone acknowledge
  output reg         wb_err_o,     // Wishbone error, unmapped address
  input  wire        port0_line3_i,  // Pin level in
  output reg         port0_line3_o,  // Pin level out
  output reg         port0_line3_oe  // Pin output enable
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg  [7:0]       func_r;
  reg  [PER_W-1:0] period_r;
  reg  [1:0]       psc_r;
  reg  [7:0]       port_out_r;
  reg  [7:0]       port_dir_r;
  reg  [PER_W-1:0] cnt_r;
  reg  [PER_W-1:0] cnt_nxt;
  reg              tone_r;
  reg              tone_nxt;
  reg              restart_r;
  reg              pin_s1_r;
  reg              pin_s2_r;
  wire             tick;
  wire             req;
  wire             wr;
  wire             lane0;
  wire             hit_func;
  wire             hit_per;
  wire             hit_out;
  wire             hit_dir;
  wire             hit_stat;
  wire             hit_any;
  wire             tone_sel;
  wire             per_wr;
  reg  [7:0]       rd_byte;

  assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign wr       = req & wb_we_i;
  assign lane0    = wb_sel_i[0];
  assign hit_func = (wb_adr_i == `TPG_OFF_FUNC);
  assign hit_per  = (wb_adr_i == `TPG_OFF_PERIOD);
  assign hit_out  = (wb_adr_i == `TPG_OFF_PORT_OUT);
  assign hit_dir  = (wb_adr_i == `TPG_OFF_PORT_DIR);
  assign hit_stat = (wb_adr_i == `TPG_OFF_STATUS);
  assign hit_any  = hit_func | hit_per | hit_out | hit_dir | hit_stat;
  assign per_wr   = wr & hit_per & lane0;
  assign tone_sel = func_r[`TPG_FUNC_TONE_BIT];

  // ----------------------------------------
  // Pin input synchroniser
  // ----------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
    end else begin
      pin_s1_r <= port0_line3_i;
      pin_s2_r <= pin_s1_r;
    end
  end

  // ----------------------------------------
  // Wishbone slave, one wait state free: ack one edge after request
  // ----------------------------------------
  always @* begin
    rd_byte = 8'h00;
    if (hit_func)
      rd_byte = func_r;
    else if (hit_out)
      rd_byte = port_out_r;
    else if (hit_dir)
      rd_byte = port_dir_r;
    else if (hit_stat)
      rd_byte = {5'h00, pin_s2_r, tone_r, tone_sel};
    // Period address reads as zero  [R9]
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o   <= 1'b0;
      wb_err_o   <= 1'b0;
      wb_dat_o   <= 32'h00000000;
      func_r     <= `TPG_RST_BYTE;
      port_out_r <= `TPG_RST_BYTE;
      port_dir_r <= `TPG_RST_BYTE;
      period_r   <= `TPG_RST_PERIOD;
      psc_r      <= `TPG_RST_PSC;
      restart_r  <= 1'b0;
    end else begin
      wb_ack_o  <= req & hit_any;
      wb_err_o  <= req & ~hit_any;
      restart_r <= per_wr; // [R10]
      if (req && hit_any && !wb_we_i)
        wb_dat_o <= {24'h000000, rd_byte};
      else
        wb_dat_o <= 32'h00000000;
      if (wr && lane0) begin
        if (hit_func)
          func_r <= wb_dat_i[7:0];
        if (hit_out)
          port_out_r <= wb_dat_i[7:0];
        if (hit_dir)
          port_dir_r <= wb_dat_i[7:0];
      end
      if (per_wr) begin
        period_r <= wb_dat_i[`TPG_PER_MSB:`TPG_PER_LSB]; // [R5]
        psc_r    <= wb_dat_i[`TPG_PSC_MSB:`TPG_PSC_LSB]; // [R7]
      end
    end
  end

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  // Restart is the registered write so new settings are already in place
  tpg_prescaler #(
    .CNT_W (5)
  ) u_psc (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .restart (restart_r),
    .sel     (psc_r),
    .tick    (tick)
  ); // [R1] [R7]

  // ----------------------------------------
  // Period counter and tone toggle
  // ----------------------------------------
  always @* begin
    cnt_nxt  = cnt_r;
    tone_nxt = tone_r;
    if (restart_r) begin
      cnt_nxt = {PER_W{1'b0}}; // [R10]
    end else if (tick && period_r != `TPG_PER_ZERO) begin // [R13]
      if (cnt_r == period_r) begin // [R11]
        cnt_nxt  = {PER_W{1'b0}}; // [R12]
        tone_nxt = ~tone_r;       // [R2] [R6]
      end else begin
        cnt_nxt = cnt_r + 1'b1;   // [R11]
      end
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= {PER_W{1'b0}};
      tone_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tone_r <= tone_nxt;
    end
  end

  // ----------------------------------------
  // Pin multiplexer
  // ----------------------------------------
  // Direction bit still rules the enable; software sets it for the tone
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port0_line3_o  <= 1'b0;
      port0_line3_oe <= 1'b0;
    end else begin
      port0_line3_o  <= tone_sel ? tone_r : port_out_r[`TPG_LINE3_BIT]; // [R3]
      port0_line3_oe <= port_dir_r[`TPG_LINE3_BIT]; // [R4]
    end
  end

endmodule // tpg_tone_gen
`default_nettype wire

// File: tpg_tone_chk_chk.sv
// Purpose: Bus and tone checks
// Assumes: One clock domain
// Notes:   Snoops the mode write
`timescale 1ns/100ps
`default_nettype none
module tpg_tone_chk (
  input wire logic        ref_clk,       // Clock
  input wire logic        rst_n,         // Reset
  input wire logic        wb_cyc_i,      // Cycle
  input wire logic        wb_stb_i,      // Strobe
  input wire logic        wb_we_i,       // Write
  input wire logic [11:0] wb_adr_i,      // Address
  input wire logic [31:0] wb_dat_i,      // Wr data
  input wire logic [31:0] wb_dat_o,      // Rd data
  input wire logic        wb_ack_o,      // Ack
  input wire logic        wb_err_o,      // Error
  input wire logic        port0_line3_o  // Pin
);
  // ----
  // Snoop
  // ----
  logic func_r;
  wire  req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  always @(posedge ref_clk or negedge rst_n)
    if (!rst_n) func_r <= 1'b0;
    else if (wb_cyc_i && wb_we_i && wb_ack_o && wb_adr_i == 12'h0f4) func_r <= wb_dat_i[3];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ----
  // Checks
  // ----
  property p_ack; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack too long");
  property p_erk; wb_err_o |=> !wb_err_o; endproperty
  a_erk: assert property (p_erk) else $error("err too long");
  property p_ans; req |=> wb_ack_o || wb_err_o; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_one; !(wb_ack_o && wb_err_o); endproperty
  a_one: assert property (p_one) else $error("ack with err");
  property p_rdp; req && !wb_we_i && wb_adr_i == 12'h0f8 |=> wb_dat_o == 32'h0; endproperty
  a_rdp: assert property (p_rdp) else $error("period read back");
  property p_idl; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_idl: assert property (p_idl) else $error("data outside ack");
  property p_err; req && wb_adr_i == 12'h200 |=> wb_err_o && !wb_ack_o; endproperty
  a_err: assert property (p_err) else $error("hole not refused");
  // Turn-off makes the pin jump, so func_r gates the hold
  property p_hlf;
    func_r && $past(func_r, 3) && $changed(port0_line3_o) |=> (!func_r || $stable(port0_line3_o))[*7];
  endproperty
  a_hlf: assert property (p_hlf) else $error("half period short");
  c_rd: cover property (wb_ack_o && !wb_we_i);
  c_er: cover property (wb_err_o);
  c_tn: cover property (func_r && $changed(port0_line3_o));
endmodule // tpg_tone_chk
bind tpg_tone_gen tpg_tone_chk i_tpg_tone_chk (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .port0_line3_o(port0_line3_o));
`default_nettype wire

// File: tpg_buzzer.sv
// Purpose: Piezo buzzer on the shared pin
// Assumes: No pull resistor
// Notes:   Released pin shows inverse level
`timescale 1ns/100ps
`default_nettype none
module tpg_buzzer (
  input  wire logic drv, // Level
  input  wire logic oe,  // Drive
  output var  logic pin  // Wire
);
  logic last_r = 1'b0;
  always @* if (oe) last_r = drv;
  always @* pin = oe ? drv : ~last_r;
endmodule // tpg_buzzer
`default_nettype wire

// File: buzzer_tone_generator_tb_top.sv
// Purpose: Self-checking tone bench
// Assumes: 10 MHz clock
// Notes:   Tone times in clocks
`timescale 1ns/100ps
`default_nettype none
module buzzer_tone_generator_tb_top;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] dat = 32'h0, rd;
  logic [15:0] lf = 16'h05e7;
  logic        eb;
  wire  [31:0] dat_o;
  wire         ack, err, po, poe, pin;
  int          miscompares = 0, num_checks = 0, n, p, d, s;
  tpg_tone_gen i_tpg_tone_gen (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'h1), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
    .port0_line3_i(pin), .port0_line3_o(po), .port0_line3_oe(poe));
  tpg_buzzer i_tpg_buzzer (.drv(po), .oe(poe), .pin(pin));
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wb(input logic [11:0] a, input logic w, input logic [7:0] v);
    int i = 0;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, v};
    // Settled answer at the negedge is what the next rising edge samples
    do begin
      @(negedge ref_clk);
      i++;
    end while (ack !== 1'b1 && err !== 1'b1 && i < 20);
    rd = dat_o;
    eb = err;
    @(posedge ref_clk);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (i >= 20) begin
      miscompares++;
      end_sim();
    end
  endtask
  // Sampled 1 ns late so the edge's updates have landed
  task automatic wchg(output int c);
    logic v;
    #1;
    v = po;
    c = 0;
    do begin
      @(posedge ref_clk);
      #1;
      c++;
    end while (po === v && c < 4000);
    if (c >= 4000) begin
      miscompares++;
      end_sim();
    end
  endtask
  initial forever #50 ref_clk = ~ref_clk;
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    wb(12'h100, 1'b1, 8'h08);
    wb(12'h0fc, 1'b1, 8'h08);
    wb(12'h0f4, 1'b1, 8'h00);
    repeat (2) @(posedge ref_clk);
    #1;
    chk({30'h0, poe, po}, 32'h3);
    wb(12'h104, 1'b0, 8'h00);
    chk(rd, 32'h4);
    wb(12'h0f8, 1'b1, 8'h01);
    wb(12'h0f8, 1'b0, 8'h00);
    chk(rd, 32'h0);
    wb(12'h200, 1'b0, 8'h00);
    chk({31'h0, eb}, 32'h1);
    $display("bus tests done");
    wb(12'h0f4, 1'b1, 8'h08);
    // Port-to-tone jump is already done when wb returns; first change is a tone toggle
    wchg(n);
    wchg(n);
    for (s = 0; s < 4; s++) begin
      lf = lfsr(lf);
      p = (s == 0) ? 63 : 1 + lf[3:0];
      d = (p + 1) * (4 << s);
      wb(12'h0f8, 1'b1, {s[1:0], 6'(p)});
      wchg(n);
      chk(n, d + 2);
      wchg(n);
      chk(n, d);
      wchg(n);
      chk(n, d);
      $display("ratio code %0d done", s);
    end
    end_sim();
  end
endmodule // buzzer_tone_generator_tb_top
`default_nettype wire
